// ### pls_status_pins.sv
// file: top of the phy link-side status and control pin logic
`timescale 1ns/10ps
module pls_status_pins
   import pls_pkg::*;
(
   input wire logic clk, // 100 MHz system clock
   input wire logic arst_n, // async reset, active low
   // shared strap / link-on pin
   input wire logic bus_mgr_strap_linkon_pin_in, // pin level
   output logic bus_mgr_strap_linkon_pin_out, // pin drive value
   output logic bus_mgr_strap_linkon_pin_oe, // high while driving
   // status pins
   input wire logic power_down_pin, // power-down request, high active
   input wire logic link_power_sense, // controller powered, high active
   input wire logic cable_power_sense, // comparator: cable power present
   input wire logic [PORTS-1:0] port_active, // per port: peer port active
   output logic cable_inactive_out, // high when no port is active
   // core events
   input wire logic link_on_msg, // one-cycle pulse: link-on message received
   output logic self_id_bmc, // bus-manager-capable self-id bit
   // control and data lines
   input wire logic [1:0] phy_link_ctl_in, // control line levels
   output logic [1:0] phy_link_ctl_out, // control drive value
   output logic phy_link_ctl_oe, // control lines driven
   input wire logic [DATA_W-1:0] phy_link_data_lines_in, // data line levels
   output logic [DATA_W-1:0] phy_link_data_lines_out, // data drive value
   output logic phy_link_data_lines_oe, // data lines driven
   // phy core stream toward the link
   input wire pls_pkg::pls_word_t tx_word, // word to send to the controller
   input wire logic tx_valid, // tx word valid
   output logic tx_ready, // buffer accepts tx word
   output pls_pkg::pls_word_t rx_word, // word the controller drove
   output logic rx_valid, // level, high while the interface is up and the phy drives nothing
   // register port
   input wire logic [3:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [7:0] reg_rdata // read data, the cycle after reg_rd
);
   import pls_pkg::*;

   typedef enum {PLS_OFF, PLS_ACTIVE, PLS_TONE} pls_state_t;

   // synchronisers for every pin input
   logic pd_s1_reg, pd_s2_reg;
   logic lps_s1_reg, lps_s2_reg;
   logic cps_s1_reg, cps_s2_reg;
   logic strap_s1_reg, strap_s2_reg;
   logic [PORTS-1:0] act_s1_reg, act_s2_reg;
   logic [1:0] ctl_s1_reg, ctl_s2_reg;
   logic [DATA_W-1:0] dat_s1_reg, dat_s2_reg;

   pls_state_t state_reg;
   logic [LINKON_CNT_W-1:0] tone_cnt_reg;
   logic tone_reg;
   logic bmc_reg;
   logic cna_reg;
   logic cps_seen_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] rdata_reg;
   logic pin_oe_reg;
   logic pin_out_reg;
   logic [1:0] pin_oe_hist_reg;
   logic ctl_oe_reg;
   logic dat_oe_reg;
   logic [1:0] ctl_out_reg;
   logic [DATA_W-1:0] dat_out_reg;
   pls_word_t rx_word_reg;
   logic rx_valid_reg;
   logic link_en;
   logic phy_owns;
   logic buf_valid;
   logic buf_take;
   pls_word_t buf_word;

   // two flops on every asynchronous input before any logic reads it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pd_s1_reg <= 1'b0;
         pd_s2_reg <= 1'b0;
         lps_s1_reg <= 1'b0;
         lps_s2_reg <= 1'b0;
         cps_s1_reg <= 1'b0;
         cps_s2_reg <= 1'b0;
         strap_s1_reg <= 1'b0;
         strap_s2_reg <= 1'b0;
         act_s1_reg <= '0;
         act_s2_reg <= '0;
         ctl_s1_reg <= 2'h0;
         ctl_s2_reg <= 2'h0;
         dat_s1_reg <= '0;
         dat_s2_reg <= '0;
      end
      else
      begin
         pd_s1_reg <= power_down_pin;
         pd_s2_reg <= pd_s1_reg;
         lps_s1_reg <= link_power_sense;
         lps_s2_reg <= lps_s1_reg;
         cps_s1_reg <= cable_power_sense;
         cps_s2_reg <= cps_s1_reg;
         strap_s1_reg <= bus_mgr_strap_linkon_pin_in;
         strap_s2_reg <= strap_s1_reg;
         act_s1_reg <= port_active;
         act_s2_reg <= act_s1_reg;
         ctl_s1_reg <= phy_link_ctl_in;
         ctl_s2_reg <= ctl_s1_reg;
         dat_s1_reg <= phy_link_data_lines_in;
         dat_s2_reg <= dat_s1_reg;
      end
   end

   // cable-inactive monitor ignores power-down on purpose: it must keep reporting while asleep
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         cna_reg <= 1'b1;
      else
         cna_reg <= ~|act_s2_reg;
   end

   // link power state machine; power-down parks everything in off
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state_reg <= PLS_OFF;
      else if (pd_s2_reg)
         state_reg <= PLS_OFF;
      else
         unique case (state_reg)
            PLS_OFF:
               if (lps_s2_reg)
                  state_reg <= PLS_ACTIVE;
               else if (link_on_msg)
                  state_reg <= PLS_TONE;
            PLS_ACTIVE:
               if (!lps_s2_reg)
                  state_reg <= PLS_OFF;
            PLS_TONE:
               if (lps_s2_reg)
                  state_reg <= PLS_ACTIVE;
               else if (ctrl_reg[CTRL_TONE_STOP])
                  state_reg <= PLS_OFF; // forced stop leaves the interface down until the controller is powered
         endcase
   end

   assign link_en = (state_reg == PLS_ACTIVE);

   // tone divider: toggles every half period while link-on is asserted
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tone_cnt_reg <= '0;
         tone_reg <= 1'b0;
      end
      else if (state_reg != PLS_TONE)
      begin
         tone_cnt_reg <= '0;
         tone_reg <= 1'b0;
      end
      else if (tone_cnt_reg == LINKON_CNT_W'(LINKON_HALF_CYC - 1))
      begin
         tone_cnt_reg <= '0;
         tone_reg <= ~tone_reg;
      end
      else
         tone_cnt_reg <= tone_cnt_reg + 1'b1;
   end

   // shared pin: the tone drive wins; the strap pull resistor is weaker than our driver
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_oe_reg <= 1'b0;
         pin_out_reg <= 1'b0;
      end
      else
      begin
         pin_oe_reg <= (state_reg == PLS_TONE);
         pin_out_reg <= tone_reg;
      end
   end

   // strap is captured only once the synchroniser has flushed our own tone, so the drive never pollutes it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bmc_reg <= 1'b0;
         pin_oe_hist_reg <= 2'h0;
      end
      else
      begin
         pin_oe_hist_reg <= {pin_oe_hist_reg[0], pin_oe_reg};
         if (!pin_oe_reg && pin_oe_hist_reg == 2'h0 && state_reg != PLS_TONE && !pd_s2_reg)
            bmc_reg <= strap_s2_reg;
      end
   end

   // cable power: live level plus a sticky seen bit; the set beats a clear on the same cycle
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         cps_seen_reg <= 1'b0;
      else if (cps_s2_reg)
         cps_seen_reg <= 1'b1;
      else if (reg_wr && reg_addr == REG_ADDR_STATUS && reg_wdata[STAT_CPS_SEEN])
         cps_seen_reg <= 1'b0;
   end

   // control register writes
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_reg <= CTRL_RESET;
      else if (reg_wr && reg_addr == REG_ADDR_CTRL)
         ctrl_reg <= reg_wdata;
   end

   // register reads answer one cycle later; unmapped reads return zero
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_reg <= 8'h00;
      else if (reg_rd)
         unique case (reg_addr)
            REG_ADDR_STATUS: rdata_reg <= {3'h0, link_en, state_reg == PLS_TONE, cna_reg,
                                           cps_seen_reg, cps_s2_reg};
            REG_ADDR_SELFID: rdata_reg <= {7'h00, bmc_reg};
            REG_ADDR_CTRL: rdata_reg <= ctrl_reg;
            default: rdata_reg <= 8'h00;
         endcase
      else
         rdata_reg <= 8'h00;
   end

   // transmit buffer: a stalled line turn keeps the word instead of dropping it
   pls_buf2 #(.W($bits(pls_word_t))) u_txbuf (
      .clk(clk),
      .arst_n(arst_n),
      .in_data(tx_word),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(buf_word),
      .out_valid(buf_valid),
      .out_ready(buf_take)
   );

   // phy takes the lines only with a word to send and lets go when empty, so the controller can claim them
   assign phy_owns = link_en && buf_valid && (ctl_s2_reg != 2'(PLS_CTL_GRANT) || ctl_oe_reg);
   assign buf_take = phy_owns && !pd_s2_reg;

   // line drivers: disabled whenever the interface is off
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctl_oe_reg <= 1'b0;
         dat_oe_reg <= 1'b0;
         ctl_out_reg <= 2'h0;
         dat_out_reg <= '0;
      end
      else
      begin
         ctl_oe_reg <= phy_owns;
         dat_oe_reg <= phy_owns && buf_valid;
         ctl_out_reg <= buf_valid ? 2'(buf_word.ctl) : 2'(PLS_CTL_IDLE);
         dat_out_reg <= buf_valid ? buf_word.data : '0;
      end
   end

   // capture what the controller drives while it holds the lines
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_word_reg <= '0;
         rx_valid_reg <= 1'b0;
      end
      else
      begin
         rx_valid_reg <= link_en && !phy_owns && !ctl_oe_reg;
         rx_word_reg <= '{data: dat_s2_reg, ctl: pls_ctl_t'(ctl_s2_reg)};
      end
   end

   assign bus_mgr_strap_linkon_pin_out = pin_out_reg;
   assign bus_mgr_strap_linkon_pin_oe = pin_oe_reg;
   assign cable_inactive_out = cna_reg;
   assign self_id_bmc = bmc_reg;
   assign phy_link_ctl_out = ctl_out_reg;
   assign phy_link_ctl_oe = ctl_oe_reg;
   assign phy_link_data_lines_out = dat_out_reg;
   assign phy_link_data_lines_oe = dat_oe_reg;
   assign rx_word = rx_word_reg;
   assign rx_valid = rx_valid_reg;
   assign reg_rdata = rdata_reg;

   a_cna_follows: assert property (@(posedge clk) disable iff (!arst_n)
      (act_s2_reg == '0) |=> cable_inactive_out)
      else $error("cable inactive not raised");
   a_cna_in_pd: assert property (@(posedge clk) disable iff (!arst_n)
      (pd_s2_reg && act_s2_reg != '0) |=> !cable_inactive_out)
      else $error("cable inactive wrong in power-down");
   a_tone_starts: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == PLS_OFF && !pd_s2_reg && !lps_s2_reg && link_on_msg) |=> ##1 bus_mgr_strap_linkon_pin_oe)
      else $error("link-on drive did not start");
   a_tone_wins: assert property (@(posedge clk) disable iff (!arst_n)
      $past(state_reg == PLS_TONE) |-> bus_mgr_strap_linkon_pin_oe)
      else $error("strap not overridden");
   a_tone_toggles: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == PLS_TONE && tone_cnt_reg == LINKON_CNT_W'(LINKON_HALF_CYC - 1)) |=> $changed(tone_reg))
      else $error("link-on tone stuck");
   a_lps_gates_if: assert property (@(posedge clk) disable iff (!arst_n)
      (!lps_s2_reg) |=> !link_en)
      else $error("interface enabled without link power");
   a_lps_stops_tone: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == PLS_TONE && lps_s2_reg && !pd_s2_reg) |=> ##1 !bus_mgr_strap_linkon_pin_oe)
      else $error("link-on not stopped");
   a_off_no_drive: assert property (@(posedge clk) disable iff (!arst_n)
      (!link_en) |=> !phy_link_ctl_oe && !phy_link_data_lines_oe)
      else $error("interface driven while disabled");
   a_pd_stops: assert property (@(posedge clk) disable iff (!arst_n)
      pd_s2_reg |=> state_reg == PLS_OFF)
      else $error("power-down did not stop logic");
   a_bmc_static: assert property (@(posedge clk) disable iff (!arst_n)
      pin_oe_reg |=> $stable(bmc_reg) ##1 $stable(bmc_reg) ##1 $stable(bmc_reg))
      else $error("strap resampled while driving");
   a_cps_read: assert property (@(posedge clk) disable iff (!arst_n)
      (reg_rd && reg_addr == REG_ADDR_STATUS) |=> reg_rdata[STAT_CPS_NOW] == $past(cps_s2_reg))
      else $error("cable power read wrong");
   a_no_contention: assert property (@(posedge clk) disable iff (!arst_n)
      phy_link_data_lines_oe |-> phy_link_ctl_oe)
      else $error("data driven without control");
   c_tone: cover property (@(posedge clk) disable iff (!arst_n) state_reg == PLS_TONE ##[1:200] link_en);
   c_tx: cover property (@(posedge clk) disable iff (!arst_n) phy_link_data_lines_oe);
   c_rx: cover property (@(posedge clk) disable iff (!arst_n) rx_valid);
   c_pd: cover property (@(posedge clk) disable iff (!arst_n) pd_s2_reg && !cable_inactive_out);
endmodule // pls_status_pins

// ### pls_pkg.sv
// package: constants and carrier types for the phy link-side status pin block
// How it works
// - strap level becomes bus-manager-capable self-id bit
// - link-on message drives 6.114 MHz on pin (6.25 MHz here: half period of 8 cycles at 100 MHz)
// - link-on drive overrides strapped input level
// - cable-inactive high when no port active
// - cable-inactive logic runs during power-down
// - cable power held in two bits, readable
// - control lines decide who drives data
// - four shared data lines, driven in turn
// - link power off disables controller interface
// - link power on stops link-on, re-enables
// - power-down stops all but cable-inactive logic (here the cable-power bits, register port and tx buffer also keep running)
package pls_pkg;
   // clock and link-on tone timing
   localparam int CLK_HZ = 100_000_000;
   localparam int LINKON_HZ = 6_114_000;
   // half period in cycles, rounded down so the tone is never slower than printed
   localparam int LINKON_HALF_CYC = (CLK_HZ / (2 * LINKON_HZ)) < 1 ? 1 : CLK_HZ / (2 * LINKON_HZ);
   localparam int LINKON_CNT_W = 4;
   // register map seen over the controller-side read path
   localparam logic [3:0] REG_ADDR_STATUS = 4'h0;
   localparam logic [3:0] REG_ADDR_SELFID = 4'h1;
   localparam logic [3:0] REG_ADDR_CTRL = 4'h2;
   localparam int STAT_CPS_NOW = 0;
   localparam int STAT_CPS_SEEN = 1;
   localparam int STAT_CABLE_INACT = 2;
   localparam int STAT_LINK_ON = 3;
   localparam int STAT_LINK_EN = 4;
   localparam int SELFID_BMC = 0;
   localparam int CTRL_TONE_STOP = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // data path widths
   localparam int DATA_W = 4;
   localparam int PORTS = 3;
   // control line encodings while the phy drives them
   typedef enum logic [1:0] {PLS_CTL_IDLE, PLS_CTL_STATUS, PLS_CTL_RECEIVE, PLS_CTL_GRANT} pls_ctl_t;
   // a word moving between the link lines and the phy core
   typedef struct packed {
      logic [DATA_W-1:0] data;
      pls_ctl_t ctl;
   } pls_word_t;
   // tri-state pin carrier
   typedef struct packed {
      logic [DATA_W-1:0] d_out;
      logic d_oe;
      logic [1:0] c_out;
      logic c_oe;
   } pls_pins_t;
endpackage

// ### pls_buf2.sv
// file: two-entry valid/ready buffer in the data path
`timescale 1ns/10ps
module pls_buf2
   import pls_pkg::*;
#(
   parameter int W = 6
)
(
   input wire logic clk, // system clock
   input wire logic arst_n, // async reset, active low
   input wire logic [W-1:0] in_data, // word from source
   input wire logic in_valid, // source has a word
   output logic in_ready, // buffer can take a word
   output logic [W-1:0] out_data, // head word
   output logic out_valid, // head word valid
   input wire logic out_ready // sink takes head word
);
   logic [W-1:0] mem_reg [2];
   logic rd_ptr_reg;
   logic wr_ptr_reg;
   logic [1:0] cnt_reg;
   logic push;
   logic pop;

   // handshakes on both sides; full refuses, so the source stalls rather than losing a word
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data = mem_reg[rd_ptr_reg];

   // storage
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
      end
      else if (push)
         mem_reg[wr_ptr_reg] <= in_data;
   end

   // pointers and fill count
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= ~wr_ptr_reg;
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   a_buf_no_overflow: assert property (@(posedge clk) disable iff (!arst_n)
      (cnt_reg == 2'h2 && !pop) |=> cnt_reg == 2'h2)
      else $error("buffer count changed while full");
   c_buf_full: cover property (@(posedge clk) disable iff (!arst_n) cnt_reg == 2'h2);
endmodule // pls_buf2

// ### pls_llc_model.sv
// file: behavioural link-layer controller facing the control and data lines
`timescale 1ns/10ps
module pls_llc_model
   import pls_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic powered, // controller supply is up
   input wire logic grant, // controller claims the lines
   input wire logic [DATA_W-1:0] drive_val, // data the controller drives
   input wire logic [1:0] ctl_out, // phy control drive value
   input wire logic ctl_oe, // phy drives control lines
   input wire logic [DATA_W-1:0] data_out, // phy data drive value
   input wire logic data_oe, // phy drives data lines
   output logic [1:0] ctl_wire, // resolved control level
   output logic [DATA_W-1:0] data_wire, // resolved data level
   output logic link_power_sense // supply level seen by the phy
);
   logic [DATA_W+1:0] got_q[$];
   // steady level only, the pulsed form of the sense is not modelled
   assign link_power_sense = powered;
   // the controller drives only once the phy has let go, so the lines never fight
   assign ctl_wire = ctl_oe ? ctl_out : (grant ? 2'h3 : 2'h1);
   assign data_wire = data_oe ? data_out : drive_val;
   // log each word the phy puts on the lines, in order
   always @(posedge clk)
   begin
      if (data_oe)
      begin
         got_q.push_back({data_wire, ctl_wire});
      end
   end
endmodule // pls_llc_model

// ### pls_status_pins_test.sv
// file: self-checking testbench of the link-side status pin block
`timescale 1ns/10ps
module pls_status_pins_test;
   import pls_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic strap_lvl = 1'b0;
   logic strap_wire, pin_out, pin_oe, cable_inactive_out, self_id_bmc, link_power_sense;
   logic power_down_pin = 1'b0;
   logic cable_power_sense = 1'b0;
   logic [PORTS-1:0] port_active = 3'h0;
   logic link_on_msg = 1'b0;
   logic [1:0] ctl_wire, ctl_out;
   logic ctl_oe, data_oe, tx_ready, rx_valid;
   logic [DATA_W-1:0] data_wire, data_out;
   pls_word_t tx_word = '0;
   pls_word_t rx_word, w;
   logic tx_valid = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, v;
   logic powered = 1'b0;
   logic grant = 1'b0;
   logic [DATA_W-1:0] drive_val = 4'h0;
   logic [5:0] exp_q[$];
   int fails = 0;
   int check_count = 0;
   int i, p, k, n;

   always #5 clk = ~clk;
   // pull resistor wins only while the pin is not driven
   assign strap_wire = pin_oe ? pin_out : strap_lvl;

   pls_status_pins i_pls_status_pins (.clk(clk), .arst_n(arst_n), .bus_mgr_strap_linkon_pin_in(strap_wire),
      .bus_mgr_strap_linkon_pin_out(pin_out), .bus_mgr_strap_linkon_pin_oe(pin_oe), .power_down_pin(power_down_pin),
      .link_power_sense(link_power_sense), .cable_power_sense(cable_power_sense), .port_active(port_active),
      .cable_inactive_out(cable_inactive_out), .link_on_msg(link_on_msg), .self_id_bmc(self_id_bmc),
      .phy_link_ctl_in(ctl_wire), .phy_link_ctl_out(ctl_out), .phy_link_ctl_oe(ctl_oe),
      .phy_link_data_lines_in(data_wire), .phy_link_data_lines_out(data_out), .phy_link_data_lines_oe(data_oe),
      .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   pls_llc_model i_pls_llc_model (.clk(clk), .powered(powered), .grant(grant), .drive_val(drive_val),
      .ctl_out(ctl_out), .ctl_oe(ctl_oe), .data_out(data_out), .data_oe(data_oe), .ctl_wire(ctl_wire),
      .data_wire(data_wire), .link_power_sense(link_power_sense));

   // one compare, four-state exact
   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task end_sim;
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // bounded wait on a settled output; running out ends the run
   task automatic wait_bit(ref logic s, input logic val);
      int c;
      for (c = 0; c < 40 && s !== val; c++)
         @(posedge clk) #1;
      check(s, val);
      if (s !== val)
         end_sim;
   endtask

   // register read: data stands only in the cycle after the strobe
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task pulse_msg;
      @(posedge clk);
      link_on_msg <= 1'b1;
      @(posedge clk);
      link_on_msg <= 0;
      #1;
   endtask

   // cycles until the tone output changes level
   task half(output int c);
      logic prev;
      prev = pin_out;
      c = 0;
      do
      begin
         @(posedge clk) #1;
         c++;
      end
      while (c < 40 && pin_out === prev);
   endtask

   // entered at a clock edge; holds the word until the edge that takes it
   task automatic send(input pls_word_t wd);
      int c;
      tx_word <= wd;
      tx_valid <= 1'b1;
      exp_q.push_back(wd);
      #1;
      for (c = 0; c < 40 && tx_ready !== 1'b1; c++)
         @(posedge clk) #1;
      check(tx_ready, 1'b1);
      if (tx_ready !== 1'b1)
         end_sim;
      @(posedge clk);
   endtask

   initial
   begin
      repeat (4) @(posedge clk);
      #1;
      check(cable_inactive_out, 1'b1);
      check({pin_oe, data_oe, ctl_oe, reg_rdata, tx_ready}, 12'h001);
      @(posedge clk);
      arst_n <= 1'b1;
      // strap level becomes the self-id bit, both polarities
      for (i = 1; i >= 0; i--)
      begin
         @(posedge clk);
         strap_lvl <= i[0];
         #1;
         wait_bit(self_id_bmc, i[0]);
         rd(REG_ADDR_SELFID, v);
         check(v, {7'h00, i[0]});
      end
      // each port alone and none, awake then powered down
      for (p = 0; p < 2; p++)
      begin
         for (i = 0; i < 4; i++)
         begin
            @(posedge clk);
            power_down_pin <= p[0];
            port_active <= (i == 0) ? 3'h0 : 3'h1 << (i - 1);
            #1;
            wait_bit(cable_inactive_out, i == 0);
            if (p == 0)
            begin
               rd(REG_ADDR_STATUS, v);
               check(v[STAT_CABLE_INACT], i == 0);
            end
         end
      end
      // link-on message is ignored while powered down
      pulse_msg;
      repeat (6) @(posedge clk);
      check(pin_oe, 1'b0);
      @(posedge clk);
      power_down_pin <= 1'b0;
      cable_power_sense <= 1'b1;
      repeat (4) @(posedge clk);
      // cable power live and sticky bits, clear by writing one
      rd(REG_ADDR_STATUS, v);
      check(v[1:0], 2'h3);
      check(v[STAT_LINK_EN], 1'b0);
      @(posedge clk);
      cable_power_sense <= 1'b0;
      repeat (4) @(posedge clk);
      rd(REG_ADDR_STATUS, v);
      check(v[1:0], 2'h2);
      wr(REG_ADDR_STATUS, 8'h02);
      rd(REG_ADDR_STATUS, v);
      check(v[1:0], 2'h0);
      rd(4'hF, v);
      check(v, 8'h00);
      // tone with the strap pulling low underneath it
      pulse_msg;
      wait_bit(pin_oe, 1'b1);
      half(n);
      half(n);
      check(n, LINKON_HALF_CYC);
      check(self_id_bmc, 1'b0);
      rd(REG_ADDR_STATUS, v);
      check({v[STAT_LINK_EN], v[STAT_LINK_ON], data_oe}, 3'h2);
      wr(REG_ADDR_CTRL, 8'h01);
      wait_bit(pin_oe, 1'b0);
      rd(REG_ADDR_STATUS, v);
      check({v[STAT_LINK_EN], v[STAT_LINK_ON]}, 2'h0);
      wr(REG_ADDR_CTRL, 8'h00);
      // second tone ends when the controller powers up
      pulse_msg;
      wait_bit(pin_oe, 1'b1);
      @(posedge clk);
      powered <= 1'b1;
      grant <= 1'b1;
      #1;
      wait_bit(pin_oe, 1'b0);
      repeat (4) @(posedge clk);
      rd(REG_ADDR_STATUS, v);
      check({v[STAT_LINK_EN], v[STAT_LINK_ON]}, 2'h2);
      // controller holds the lines: two words fill the buffer, tx_ready drops and nothing is driven
      @(posedge clk);
      for (k = 0; k < 5; k++)
      begin
         w.data = k[3:0] ^ 4'h9;
         w.ctl = k[0] ? PLS_CTL_RECEIVE : PLS_CTL_STATUS;
         send(w);
         if (k == 1)
         begin
            tx_valid <= 1'b0;
            #1;
            check({tx_ready, data_oe}, 2'h0);
            @(posedge clk);
            grant <= 1'b0;
         end
      end
      tx_valid <= 1'b0;
      repeat (20) @(posedge clk);
      check(i_pls_llc_model.got_q.size(), 5);
      for (k = 0; k < 5 && k < i_pls_llc_model.got_q.size(); k++)
         check(i_pls_llc_model.got_q[k], exp_q[k]);
      // controller drives the data lines back toward the phy
      @(posedge clk);
      drive_val <= 4'h5;
      #1;
      wait_bit(rx_valid, 1'b1);
      repeat (4) @(posedge clk);
      #1;
      check({rx_valid, rx_word.data}, 5'h15);
      end_sim;
   end
endmodule // pls_status_pins_test
